// ==== src/cip_pkg.sv ====
/*
  shared constants for the charge indicator pwm block: register offsets,
  field positions, reset values, charger state codes and timing counts.
  assumes a 100 MHz system clock and a 32-bit register port.
*/
package cip_pkg;

  // system clock rate in hertz
  localparam longint CLK_HZ        = 100_000_000;
  // pwm slots in one repetition period
  localparam int     SLOTS         = 32;
  // blink rates in millihertz, as selected by blink_rate_select
  localparam longint RATE_1HZ_MHZ   = 1000;
  localparam longint RATE_0P5HZ_MHZ = 500;
  localparam longint RATE_256HZ_MHZ = 256000;
  localparam longint RATE_8HZ_MHZ   = 8000;
  // ramp step interval: one step per 1/64 s
  localparam longint RAMP_STEPS_PER_S = 64;

  // cycles per pwm slot, rounded down, for each blink rate
  localparam longint SLOT_CYC_1HZ   = (CLK_HZ * 1000) / (SLOTS * RATE_1HZ_MHZ);
  localparam longint SLOT_CYC_0P5HZ = (CLK_HZ * 1000) / (SLOTS * RATE_0P5HZ_MHZ);
  localparam longint SLOT_CYC_256HZ = (CLK_HZ * 1000) / (SLOTS * RATE_256HZ_MHZ);
  localparam longint SLOT_CYC_8HZ   = (CLK_HZ * 1000) / (SLOTS * RATE_8HZ_MHZ);
  // cycles per ramp step, rounded down
  localparam longint RAMP_CYC       = CLK_HZ / RAMP_STEPS_PER_S;

  // blink rate select codes
  localparam logic [1:0] RATE_SEL_1HZ   = 2'h0;
  localparam logic [1:0] RATE_SEL_0P5HZ = 2'h1;
  localparam logic [1:0] RATE_SEL_256HZ = 2'h2;
  localparam logic [1:0] RATE_SEL_8HZ   = 2'h3;

  // charger state codes from the charger state machine
  localparam logic [1:0] CHG_OFF      = 2'h0;
  localparam logic [1:0] CHG_CHARGING = 2'h1;
  localparam logic [1:0] CHG_FAULT    = 2'h2;
  localparam logic [1:0] CHG_COMPLETE = 2'h3;

  // duty values
  localparam logic [5:0] DUTY_FULL = 6'h20;
  localparam logic [5:0] DUTY_HALF = 6'h10;
  localparam logic [5:0] DUTY_ZERO = 6'h00;

  // register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DUTY   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // control register fields
  localparam int CTRL_RATE_LSB  = 0;
  localparam int CTRL_STYLE_BIT = 2;
  localparam int CTRL_OVRD_BIT  = 3;
  localparam int CTRL_MANON_BIT = 4;
  localparam int CTRL_RAMP_BIT  = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [5:0] DUTY_RESET = 6'h00;

  // status register fields
  localparam int STAT_DUTY_LSB = 0;
  localparam int STAT_SINK_BIT = 6;
  localparam int STAT_RAMP_BIT = 7;
  localparam int STAT_CHG_LSB  = 8;

  // indicator source, one-hot
  typedef enum logic [3:0] {
    CIP_IND_OFF    = 4'b0001,
    CIP_IND_STEADY = 4'b0010,
    CIP_IND_FLASH  = 4'b0100,
    CIP_IND_MANUAL = 4'b1000
  } cip_ind_type;

endpackage : cip_pkg

// ==== src/cip_charge_indicator_pwm.sv ====
/*
  charge indicator pwm: 32-slot duty generator with selectable repetition
  rate, hardware duty ramp and charger-state driven indication pattern.
  assumes the charger state input and register port are on sys_clk; the
  register port reads back one cycle after the read strobe.
*/
`timescale 1ns/100ps

// What this block does
// RULE_01 - two-bit rate select: 1 Hz default, 0.5 Hz, 256 Hz, 8 Hz
// RULE_02 - duty setting from 0 to 32 of 32 slots per period
// RULE_03 - style 0: charging steady on, fault flashing, complete off
// RULE_04 - style 1: charging flashing, fault steady on, complete off
// RULE_05 - automatic flash is 1 Hz half duty, steady full; off when charger off
// RULE_06 - indicator follows charger state automatically unless overridden
// RULE_07 - override set: manual bit alone turns indicator on or off
// RULE_08 - override clear: software cannot force on, duty stays writable
// RULE_09 - ramp moves duty one step toward target every 1/64 s
// RULE_10 - every duty change ramps if enabled, else applies at once
// RULE_11 - blinking comes from lowering the repetition rate, duty sets on time
// RULE_12 - slot counter at 32x rate, sink on while slot below duty
module cip_charge_indicator_pwm
  import cip_pkg::*;
#(
  parameter int unsigned SLOT_CYC_1HZ_P   = 32'(SLOT_CYC_1HZ),
  parameter int unsigned SLOT_CYC_0P5HZ_P = 32'(SLOT_CYC_0P5HZ),
  parameter int unsigned SLOT_CYC_256HZ_P = 32'(SLOT_CYC_256HZ),
  parameter int unsigned SLOT_CYC_8HZ_P   = 32'(SLOT_CYC_8HZ),
  parameter int unsigned RAMP_CYC_P       = 32'(RAMP_CYC)
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [31:0] regRdData,
  input  wire logic [1:0]  chargerState,
  output logic             chargeIndicatorSink
);

  // step a duty value one slot toward a target
  function automatic logic [5:0] stepToward(input logic [5:0] cur, input logic [5:0] tgt);
    if (cur < tgt) begin
      stepToward = cur + 6'h01;
    end else if (cur > tgt) begin
      stepToward = cur - 6'h01;
    end else begin
      stepToward = cur;
    end
  endfunction : stepToward

  // slot length in cycles for a rate code
  function automatic logic [31:0] slotCycles(input logic [1:0] sel);
    case (sel)
      RATE_SEL_0P5HZ: slotCycles = SLOT_CYC_0P5HZ_P;
      RATE_SEL_256HZ: slotCycles = SLOT_CYC_256HZ_P;
      RATE_SEL_8HZ:   slotCycles = SLOT_CYC_8HZ_P;
      default:        slotCycles = SLOT_CYC_1HZ_P;
    endcase
  endfunction : slotCycles

  logic [5:0]  ctrl_reg;
  logic [5:0]  dutySet_reg;
  logic [5:0]  dutyNow_reg;
  logic [5:0]  dutyNow_next;
  logic [31:0] preCnt_reg;
  logic [31:0] rampCnt_reg;
  logic [4:0]  slotIdx_reg;
  logic        sink_reg;
  logic [31:0] rdData_reg;
  cip_ind_type ind_reg;
  cip_ind_type ind_next;

  // control fields
  wire logic [1:0] blinkRateSelect       = ctrl_reg[CTRL_RATE_LSB +: 2];
  wire logic       indicationStyleSelect = ctrl_reg[CTRL_STYLE_BIT];
  wire logic       softwareOverride      = ctrl_reg[CTRL_OVRD_BIT];
  wire logic       manualIndicatorOn     = ctrl_reg[CTRL_MANON_BIT];
  wire logic       dutyRampEnable        = ctrl_reg[CTRL_RAMP_BIT];

  // register decode
  wire logic wrCtrl = regWrStb && (regAddr == ADDR_CTRL);
  wire logic wrDuty = regWrStb && (regAddr == ADDR_DUTY);
  // a duty beyond full has no slot to compare against, so writes above
  // full saturate at full instead of wrapping to a small on time
  wire logic [5:0] dutyWrClamped =
    (regWrData[31:6] != 26'h0 || regWrData[5:0] > DUTY_FULL) ? DUTY_FULL : regWrData[5:0];

  // automatic pattern per style: style 0 steady while charging and flashing on a
  // fault, style 1 the other way round; complete and charger off stay dark
  cip_ind_type chargingInd;
  cip_ind_type faultInd;
  assign chargingInd = indicationStyleSelect ? CIP_IND_FLASH
                                             : CIP_IND_STEADY; // RULE_03 RULE_04
  assign faultInd    = indicationStyleSelect ? CIP_IND_STEADY
                                             : CIP_IND_FLASH;  // RULE_03 RULE_04

  // indicator source from charger state and style
  always_comb begin
    ind_next = CIP_IND_OFF;
    if (softwareOverride) begin
      ind_next = manualIndicatorOn ? CIP_IND_MANUAL : CIP_IND_OFF; // RULE_07
    end else begin
      case (chargerState) // RULE_06
        CHG_CHARGING: ind_next = chargingInd; // RULE_03 RULE_04
        CHG_FAULT:    ind_next = faultInd;    // RULE_03 RULE_04
        default:      ind_next = CIP_IND_OFF; // RULE_05 RULE_08
      endcase
    end
  end

  // target duty and rate per source
  logic [5:0] targetDuty;
  logic [1:0] rateNow;
  always_comb begin
    targetDuty = DUTY_ZERO;
    rateNow    = blinkRateSelect;
    case (ind_reg)
      CIP_IND_STEADY: targetDuty = DUTY_FULL; // RULE_05
      CIP_IND_FLASH: begin
        targetDuty = DUTY_HALF; // RULE_05
        rateNow    = RATE_SEL_1HZ;
      end
      CIP_IND_MANUAL: targetDuty = dutySet_reg; // RULE_02 RULE_07
      default:        targetDuty = DUTY_ZERO;
    endcase
  end

  // timing strobes
  wire logic [31:0] slotLen  = slotCycles(rateNow); // RULE_01 RULE_11
  wire logic        slotEnd  = (preCnt_reg >= slotLen - 32'h1); // RULE_12
  wire logic        rampTick = (rampCnt_reg >= RAMP_CYC_P - 32'h1); // RULE_09
  wire logic        ramping  = (dutyNow_reg != targetDuty);

  // duty follows target: stepped on ramp ticks, or at once with ramp off
  assign dutyNow_next = !dutyRampEnable ? targetDuty :              // RULE_10
                        rampTick ? stepToward(dutyNow_reg, targetDuty) : // RULE_09
                        dutyNow_reg;

  // read mux
  wire logic [31:0] statusWord = {22'h0, chargerState, ramping, sink_reg, dutyNow_reg};
  wire logic [31:0] rdMux =
    (regAddr == ADDR_CTRL)   ? {26'h0, ctrl_reg} :
    (regAddr == ADDR_DUTY)   ? {26'h0, dutySet_reg} :
    (regAddr == ADDR_STATUS) ? statusWord : 32'h0;

  // software registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg    <= CTRL_RESET;
      dutySet_reg <= DUTY_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_reg <= regWrData[5:0]; // RULE_01
      end
      if (wrDuty) begin
        dutySet_reg <= dutyWrClamped; // RULE_02 RULE_08
      end
    end
  end

  // read data, valid the cycle after the strobe only
  // zero outside the answer cycle, so a stale word never looks like a fresh read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= 32'h0;
    end else begin
      rdData_reg <= regRdStb ? rdMux : 32'h0;
    end
  end

  // indicator source and applied duty
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_reg     <= CIP_IND_OFF;
      dutyNow_reg <= DUTY_ZERO;
    end else begin
      ind_reg     <= ind_next;
      dutyNow_reg <= dutyNow_next;
    end
  end

  // ramp step timer, free running
  // not restarted by writes, so frequent rewrites cannot stall a ramp in progress
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rampCnt_reg <= 32'h0;
    end else begin
      rampCnt_reg <= rampTick ? 32'h0 : rampCnt_reg + 32'h1; // RULE_09
    end
  end

  // slot prescaler and slot index
  // the >= compare ends an overlong slot at once after a switch to a faster rate
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_reg  <= 32'h0;
      slotIdx_reg <= 5'h0;
    end else begin
      preCnt_reg <= slotEnd ? 32'h0 : preCnt_reg + 32'h1; // RULE_12
      if (slotEnd) begin
        slotIdx_reg <= slotIdx_reg + 5'h1; // RULE_12
      end
    end
  end

  // sink drive: on while slot index below applied duty
  // full duty exceeds every 5-bit index, so the sink stays on with no gap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_reg <= 1'b0;
    end else begin
      sink_reg <= ({1'b0, slotIdx_reg} < dutyNow_reg); // RULE_02 RULE_12
    end
  end

  assign regRdData           = rdData_reg;
  assign chargeIndicatorSink = sink_reg;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_rate_slot_len: assert property ( // RULE_01
    (ind_reg != CIP_IND_FLASH && blinkRateSelect == RATE_SEL_256HZ)
      |-> slotLen == SLOT_CYC_256HZ_P)
    else $error("slot length does not follow rate select");

  a_sink_below_duty: assert property ( // RULE_02
    1'b1 |=> sink_reg == ({1'b0, $past(slotIdx_reg)} < $past(dutyNow_reg)))
    else $error("sink does not match slot and duty");

  a_style0_charging: assert property ( // RULE_03
    (!softwareOverride && !indicationStyleSelect && chargerState == CHG_CHARGING)
      |=> targetDuty == DUTY_FULL)
    else $error("style 0 charging not steady on");

  a_style1_charging: assert property ( // RULE_04
    (!softwareOverride && indicationStyleSelect && chargerState == CHG_CHARGING)
      |=> targetDuty == DUTY_HALF && rateNow == RATE_SEL_1HZ)
    else $error("style 1 charging not flashing");

  a_off_when_idle: assert property ( // RULE_05
    (!softwareOverride && chargerState == CHG_OFF && !dutyRampEnable)
      ##1 (!softwareOverride && !dutyRampEnable) |=> dutyNow_reg == DUTY_ZERO)
    else $error("indicator not off with charger off");

  a_fault_style0: assert property ( // RULE_06
    (!softwareOverride && !indicationStyleSelect && chargerState == CHG_FAULT)
      |=> ind_reg == CIP_IND_FLASH)
    else $error("fault not flashing under automatic control");

  a_override_off: assert property ( // RULE_07
    (softwareOverride && !manualIndicatorOn) |=> targetDuty == DUTY_ZERO)
    else $error("override off leaves indicator driven");

  a_no_force_on: assert property ( // RULE_08
    (!softwareOverride && chargerState == CHG_COMPLETE) |=> ind_reg == CIP_IND_OFF)
    else $error("software forced indicator without override");

  a_ramp_step: assert property ( // RULE_09
    (dutyRampEnable && !rampTick) ##1 dutyRampEnable |-> dutyNow_reg == $past(dutyNow_reg)
      || $past(rampTick))
    else $error("duty moved between ramp ticks");

  a_ramp_one_slot: assert property ( // RULE_09
    (dutyRampEnable && rampTick && ramping) |=>
      (dutyNow_reg == $past(dutyNow_reg) + 6'h01) || (dutyNow_reg == $past(dutyNow_reg) - 6'h01))
    else $error("ramp step not one slot");

  a_no_ramp_direct: assert property ( // RULE_10
    !dutyRampEnable |=> dutyNow_reg == $past(targetDuty))
    else $error("duty not applied at once with ramp off");

  a_flash_one_hz: assert property ( // RULE_11
    ind_reg == CIP_IND_FLASH |-> slotLen == SLOT_CYC_1HZ_P)
    else $error("flash rate not 1 Hz");

  a_slot_advance: assert property ( // RULE_12
    slotEnd |=> slotIdx_reg == $past(slotIdx_reg) + 5'h1 && preCnt_reg == 32'h0)
    else $error("slot index did not advance");

  // slot length and ramp timer
  a_slot_length: assert property ( // RULE_12
    (slotEnd && $stable(rateNow))
      |-> preCnt_reg == slotLen - 32'h1)
    else $error("slot ended away from its length");

  a_ramp_restart: assert property ( // RULE_09
    rampTick
      |=> rampCnt_reg == 32'h0)
    else $error("ramp timer did not restart");

  a_ramp_hold: assert property ( // RULE_09
    (dutyRampEnable && !ramping)
      |=> dutyNow_reg == $past(dutyNow_reg))
    else $error("duty moved with target reached");

  // pattern and sink checks
  a_style1_fault: assert property ( // RULE_04
    (!softwareOverride && indicationStyleSelect && chargerState == CHG_FAULT)
      |=> ind_reg == CIP_IND_STEADY)
    else $error("style 1 fault not steady on");

  a_complete_off: assert property ( // RULE_03 RULE_04
    (!softwareOverride && chargerState == CHG_COMPLETE && !dutyRampEnable)
      ##1 (!softwareOverride && !dutyRampEnable) |=> dutyNow_reg == DUTY_ZERO)
    else $error("indicator not off with charge complete");

  a_manual_select: assert property ( // RULE_07
    (softwareOverride && manualIndicatorOn)
      |=> ind_reg == CIP_IND_MANUAL)
    else $error("override on does not hand the indicator to software");

  a_sink_zero_duty: assert property ( // RULE_02
    dutyNow_reg == DUTY_ZERO
      |=> !sink_reg)
    else $error("sink on at zero duty");

  a_sink_full_duty: assert property ( // RULE_02
    dutyNow_reg == DUTY_FULL
      |=> sink_reg)
    else $error("sink off at full duty");

  // register port checks
  a_ctrl_write: assert property ( // RULE_01
    wrCtrl
      |=> ctrl_reg == $past(regWrData[5:0]))
    else $error("control write did not land");

  a_duty_clamp: assert property ( // RULE_02
    (wrDuty && regWrData > {26'h0, DUTY_FULL})
      |=> dutySet_reg == DUTY_FULL)
    else $error("duty write above full not clamped");

  a_rd_one_cycle: assert property ( // read port
    !regRdStb
      |=> regRdData == 32'h0)
    else $error("read data outside its answer cycle");

  a_rd_ctrl_data: assert property ( // read port
    (regRdStb && regAddr == ADDR_CTRL)
      |=> regRdData == {26'h0, $past(ctrl_reg)})
    else $error("control read back wrong");

  a_unmapped_read: assert property ( // read port
    (regRdStb && regAddr != ADDR_CTRL && regAddr != ADDR_DUTY && regAddr != ADDR_STATUS)
      |=> regRdData == 32'h0)
    else $error("unmapped read not zero");

  c_ramp_up:     cover property (dutyRampEnable && rampTick && dutyNow_reg < targetDuty);
  c_manual_on:   cover property (ind_reg == CIP_IND_MANUAL && sink_reg);
  c_flash_fault: cover property (ind_reg == CIP_IND_FLASH && chargerState == CHG_FAULT);
  c_slot_wrap:   cover property (slotEnd && slotIdx_reg == 5'h1f);
  c_style1_flash: cover property (ind_reg == CIP_IND_FLASH && chargerState == CHG_CHARGING);

endmodule : cip_charge_indicator_pwm

// ==== dv/cip_charger_model.sv ====
/*
  charger state model: presents a charger state code to the indicator block.
  assumes the bench asks for a state on reqState, synchronous to sys_clk.
*/
`timescale 1ns/100ps

module cip_charger_model
  import cip_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] reqState,
  output logic      [1:0] chargerState
);
  // the state moves just after a clock edge and shows off during reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chargerState <= CHG_OFF;
    end else begin
      chargerState <= reqState;
    end
  end
endmodule : cip_charger_model

// ==== dv/tb_charge_indicator_pwm.sv ====
/*
  self-checking bench for the charge indicator pwm block.
  assumes short slot and ramp counts set at the instance; sink on time is
  counted over whole repetition periods, except the 128-cycle manual off window.
*/
`timescale 1ns/100ps

module tb_charge_indicator_pwm
  import cip_pkg::*;
();
  localparam int unsigned SCT [4] = '{8, 16, 2, 4};
  localparam int          RC      = 5;

  logic        sys_clk;
  logic        rst_n;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrStb;
  logic        regRdStb;
  logic [31:0] regRdData;
  logic [1:0]  reqState;
  logic [1:0]  chargerState;
  logic        chargeIndicatorSink;
  int          errCount;
  int          nCompared;

  // design and charger model
  cip_charge_indicator_pwm #(.SLOT_CYC_1HZ_P(SCT[0]), .SLOT_CYC_0P5HZ_P(SCT[1]),
    .SLOT_CYC_256HZ_P(SCT[2]), .SLOT_CYC_8HZ_P(SCT[3]), .RAMP_CYC_P(RC)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .chargerState(chargerState), .chargeIndicatorSink(chargeIndicatorSink));
  cip_charger_model u_chg (.sys_clk(sys_clk), .rst_n(rst_n), .reqState(reqState),
    .chargerState(chargerState));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge sys_clk);
    regWrStb  <= 1'b0;
  endtask : reg_wr

  // read data is taken in the single cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask : reg_rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    reg_rd(a, d);
    chk(d, exp, what);
  endtask : chk_rd

  // settle, then count sink-on cycles over a window of per cycles
  task automatic chk_sink(input int settle, input int per, input int exp, input string what);
    int c;
    c = 0;
    repeat (settle) @(posedge sys_clk);
    repeat (per) @(negedge sys_clk) if (chargeIndicatorSink === 1'b1) c++;
    chk(32'(c), 32'(exp), what);
  endtask : chk_sink

  task automatic t_reset();
    chk_rd(ADDR_CTRL, 32'h0, "ctrl reset");
    chk_rd(ADDR_DUTY, 32'h0, "duty reset");
    chk_rd(ADDR_STATUS, 32'h0, "status reset");
    reg_wr(8'h0c, 32'hff);
    chk_rd(8'h0c, 32'h0, "unmapped read");
  endtask : t_reset

  // automatic pattern for every charger state; rate select must not matter
  task automatic t_auto(input logic styleBit);
    int exp;
    logic [31:0] d;
    reg_wr(ADDR_CTRL, {29'h0, styleBit, RATE_SEL_8HZ});
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      reqState <= 2'(i);
      exp = (i == 1) ? (styleBit ? 16 : 32) : (i == 2) ? (styleBit ? 32 : 16) : 0;
      chk_sink(300, 32 * SCT[0], exp * SCT[0], "auto");
      reg_rd(ADDR_STATUS, d);
      chk({22'h0, d[9:8], 2'h0, d[5:0]}, {22'h0, 2'(i), 2'h0, 6'(exp)}, "status");
    end
  endtask : t_auto

  // override with manual on: duty and rate come from the registers
  task automatic t_manual();
    int dt [4];
    dt = '{13, 32, 0, 7};
    @(posedge sys_clk);
    reqState <= CHG_FAULT;
    for (int s = 0; s < 4; s++) begin
      reg_wr(ADDR_CTRL, 32'h18 | s);
      reg_wr(ADDR_DUTY, 32'(dt[s]));
      chk_sink(64 * SCT[s], 32 * SCT[s], dt[s] * SCT[s], "manual");
    end
    reg_wr(ADDR_CTRL, 32'h08);
    chk_sink(40, 128, 0, "manual off");
    reg_wr(ADDR_DUTY, 32'h28);
    chk_rd(ADDR_DUTY, 32'h20, "duty clamp");
  endtask : t_manual

  task automatic t_no_force();
    @(posedge sys_clk);
    reqState <= CHG_OFF;
    reg_wr(ADDR_CTRL, 32'h10);
    reg_wr(ADDR_DUTY, 32'h20);
    chk_sink(300, 256, 0, "no force");
    chk_rd(ADDR_DUTY, 32'h20, "duty writable");
  endtask : t_no_force

  // poll the applied duty until it meets the target, bounded
  task automatic ramp_to(input logic [5:0] tgt, input int steps);
    logic [31:0] d;
    int cyc;
    logic sawRamp;
    reg_wr(ADDR_DUTY, {26'h0, tgt});
    cyc = 0;
    sawRamp = 1'b0;
    do begin
      reg_rd(ADDR_STATUS, d);
      sawRamp = sawRamp | d[7];
      cyc += 2;
    end while (d[5:0] !== tgt && cyc < 400);
    if (cyc >= 400) begin
      errCount++;
      $display("unexpected at %0t: ramp did not reach its target", $time);
    end
    chk({31'h0, sawRamp}, 32'h1, "ramping flag seen");
    chk({31'h0, d[7]}, 32'h0, "ramping flag clear");
    chk(32'(cyc >= (steps - 1) * RC && cyc <= steps * RC + 6), 32'h1, "ramp");
  endtask : ramp_to

  task automatic t_ramp();
    logic [31:0] d;
    reg_wr(ADDR_CTRL, 32'h1a);
    reg_wr(ADDR_DUTY, 32'h0);
    repeat (5) @(posedge sys_clk);
    reg_wr(ADDR_CTRL, 32'h3a);
    ramp_to(6'h08, 8);
    ramp_to(6'h04, 4);
    reg_wr(ADDR_CTRL, 32'h1a);
    reg_wr(ADDR_DUTY, 32'h14);
    repeat (3) @(posedge sys_clk);
    reg_rd(ADDR_STATUS, d);
    chk({26'h0, d[5:0]}, 32'h14, "immediate");
  endtask : t_ramp

  // watchdog on the whole run
  initial begin
    repeat (60000) @(posedge sys_clk);
    errCount++;
    $display("unexpected at %0t: run too long", $time);
    conclude();
  end

  // main sequence
  initial begin
    rst_n     = 1'b0;
    regAddr   = 8'h00;
    regWrData = 32'h0;
    regWrStb  = 1'b0;
    regRdStb  = 1'b0;
    reqState  = CHG_OFF;
    errCount  = 0;
    nCompared = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_auto(1'b0);
    t_auto(1'b1);
    t_manual();
    t_no_force();
    t_ramp();
    conclude();
  end
endmodule : tb_charge_indicator_pwm
